// [rtl/bcrf_decoder.sv]
// control-flow decoder: in-page branch, short_vector_jump, returns, idle op and flag updates
// Function
// - in-page branch with status flag set loads six-bit immediate into low pc bits
// - upper pc bits come from advanced pc, so last-address branch lands next page
// - in-page branch with status flag clear only sets status flag and continues
// - long call stores pc at stack pointer slot, decrements pointer, loads target
// - short-vector call pushes like long call; target 8n+6, or 134 when n is zero
// - subroutine exit increments stack pointer then loads pc from that slot
// - interrupt exit increments pointer and restores address and flags from slot
// - interrupt exit then sets the interrupt master enable to one
// - all-zero opcode does nothing, flags unchanged, goes to next instruction
// - carry flag from msb adder carry or msb borrow, inverted when specified
// - zero indication is one only when the four-bit value is all zero
// - each flag loads its listed value or stays untouched when marked unchanged
// - for marked instructions zero flag reflects value written into accumulator
// - l register inc and dec derive zero and status flags from their result
// - accumulator shifts and rotates put the shifted-out bit into carry
// - saved or used pc is the address of the next instruction
`timescale 1ns/1ps
`include "bcrf_consts.svh"
module bcrf_decoder #(
   parameter int PC_W = `BCRF_PC_W,
   parameter int SP_W = `BCRF_SP_W
) (
   input wire logic clk_sys, // system clock, 10 MHz
   input wire logic rstn, // asynchronous reset, active low
   output logic pm_rd, // program memory read strobe
   output logic [PC_W-1:0] pm_addr, // program memory address
   input wire logic [7:0] pm_data, // opcode byte, cycle after pm_rd
   output logic other_go, // pulse: opcode for another unit
   output logic [7:0] other_op, // that opcode
   input wire logic upd_valid, // apply flag update this cycle
   input bcrf_pkg::bcrf_fsel_t carry_sel, // carry flag action
   input bcrf_pkg::bcrf_fsel_t zero_sel, // zero flag action
   input bcrf_pkg::bcrf_fsel_t stat_sel, // status flag action
   input bcrf_pkg::bcrf_csrc_t cy_src, // carry source
   input bcrf_pkg::bcrf_zsrc_t z_src, // zero source
   input wire logic add_carry, // adder msb carry
   input wire logic sub_borrow, // subtractor msb borrow
   input wire logic shift_out, // accumulator shift-out bit
   input wire logic [3:0] alu_res, // alu result
   input wire logic [3:0] acc_val, // accumulator write value
   input wire logic [3:0] l_res, // l register result
   input wire logic ime_clr, // pulse: interrupt entry clears enable
   output logic ime, // interrupt master enable
   output logic [2:0] flags, // {status, zero, carry}
   input wire logic [2:0] reg_addr, // register address
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [15:0] reg_rdata // register read data, cycle after reg_rd
);
   import bcrf_pkg::*;

   // ****************************************************************
   // state and registers
   // ****************************************************************
   bcrf_state_t state_q, state_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [SP_W-1:0] sp_q, sp_d;
   logic [2:0] flags_q, flags_d;
   logic ime_q, ime_d;
   logic run_q;
   logic [2:0] tgt_hi_q;
   logic int_exit_q;
   logic [15:0] rdata_q, rdata_d;

   // ****************************************************************
   // opcode decode
   // ****************************************************************
   wire [7:0] op = pm_data;
   wire in_decode = (state_q == ST_DECODE);
   wire is_idle = (op == `BCRF_OP_IDLE);
   wire is_sub_exit = (op == `BCRF_OP_SUB_EXIT);
   wire is_int_exit = (op == `BCRF_OP_INT_EXIT);
   wire is_page_br = (op[7:6] == `BCRF_PFX_PAGE);
   wire is_call = (op[7:3] == `BCRF_PFX_CALL);
   wire is_vec_call = (op[7:4] == `BCRF_PFX_VEC);
   wire is_other = ~(is_idle | is_sub_exit | is_int_exit | is_page_br | is_call | is_vec_call);
   wire stat_fl = flags_q[2];

   // page branch keeps the already advanced upper pc bits
   wire [PC_W-1:0] page_tgt = {pc_q[PC_W-1:6], op[5:0]};
   wire [PC_W-1:0] vec_tgt = (op[3:0] == 4'h0) ? `BCRF_VEC_ZERO :
      PC_W'({op[3:0], 3'h0}) + `BCRF_VEC_OFS;
   wire [PC_W-1:0] call_tgt = PC_W'({tgt_hi_q, pm_data});
   wire [PC_W-1:0] pc_inc = pc_q + PC_W'(1);
   wire [SP_W-1:0] sp_dec = sp_q - SP_W'(1);
   wire [SP_W-1:0] sp_inc = sp_q + SP_W'(1);

   // ****************************************************************
   // return stack
   // ****************************************************************
   wire push = (in_decode & is_vec_call) | (state_q == ST_DECODE2);
   wire pop_rd = (state_q == ST_POP);
   wire [PC_W+2:0] stk_wdata = {flags_q, pc_q};
   logic [PC_W+2:0] stk_rdata;

   bcrf_stack_mem #(
      .W(PC_W + 3),
      .AW(SP_W)
   ) bcrf_stack_mem_i (
      .clk_sys(clk_sys),
      .we(push),
      .waddr(sp_q),
      .wdata(stk_wdata),
      .re(pop_rd),
      .raddr(sp_q),
      .rdata_q(stk_rdata)
   );

   // ****************************************************************
   // flag update from other instruction classes
   // ****************************************************************
   logic [2:0] flags_ext;

   bcrf_flag_unit bcrf_flag_unit_i (
      .carry_sel(carry_sel),
      .zero_sel(zero_sel),
      .stat_sel(stat_sel),
      .cy_src(cy_src),
      .z_src(z_src),
      .add_carry(add_carry),
      .sub_borrow(sub_borrow),
      .shift_out(shift_out),
      .alu_res(alu_res),
      .acc_val(acc_val),
      .l_res(l_res),
      .flags(flags_q),
      .flags_n(flags_ext)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   assign pm_rd = ((state_q == ST_FETCH) & run_q) | (state_q == ST_FETCH2);
   assign pm_addr = pc_q;
   assign other_go = in_decode & is_other;
   assign other_op = pm_data;

   always_comb
   begin
      state_d = state_q;
      pc_d = pc_q;
      sp_d = sp_q;
      flags_d = upd_valid ? flags_ext : flags_q;
      case (state_q)
         ST_FETCH:
         begin
            if (run_q)
            begin
               pc_d = pc_inc;
               state_d = ST_DECODE;
            end
         end
         ST_DECODE:
         begin
            state_d = ST_FETCH;
            if (is_page_br)
            begin
               if (stat_fl)
               begin
                  pc_d = page_tgt;
               end
               else
               begin
                  flags_d[2] = 1'b1;
               end
            end
            else if (is_call)
            begin
               state_d = ST_FETCH2;
            end
            else if (is_vec_call)
            begin
               sp_d = sp_dec;
               pc_d = vec_tgt;
            end
            else if (is_sub_exit | is_int_exit)
            begin
               sp_d = sp_inc;
               state_d = ST_POP;
            end
         end
         ST_FETCH2:
         begin
            pc_d = pc_inc;
            state_d = ST_DECODE2;
         end
         ST_DECODE2:
         begin
            sp_d = sp_dec;
            pc_d = call_tgt;
            state_d = ST_FETCH;
         end
         ST_POP:
         begin
            state_d = ST_LOAD;
         end
         default:
         begin
            pc_d = stk_rdata[PC_W-1:0];
            if (int_exit_q)
            begin
               flags_d = stk_rdata[PC_W+2:PC_W];
            end
            state_d = ST_FETCH;
         end
      endcase
      // software may move pc and stack pointer only while stopped
      if (reg_wr & ~run_q & (state_q == ST_FETCH))
      begin
         if (reg_addr == `BCRF_REG_PC)
         begin
            pc_d = reg_wdata[PC_W-1:0];
         end
         else if (reg_addr == `BCRF_REG_SP)
         begin
            sp_d = reg_wdata[SP_W-1:0];
         end
      end
   end

   // restore wins over a same-cycle clear from interrupt entry
   assign ime_d = ((state_q == ST_LOAD) & int_exit_q) ? 1'b1 : (ime_clr ? 1'b0 : ime_q);

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_FETCH;
         pc_q <= `BCRF_PC_RST;
         sp_q <= `BCRF_SP_RST;
         flags_q <= 3'h0;
         ime_q <= 1'b0;
         tgt_hi_q <= 3'h0;
         int_exit_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         flags_q <= flags_d;
         ime_q <= ime_d;
         if (in_decode)
         begin
            tgt_hi_q <= op[2:0];
            int_exit_q <= is_int_exit;
         end
      end
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   wire sel_ctrl = (reg_addr == `BCRF_REG_CTRL);
   wire sel_pc = (reg_addr == `BCRF_REG_PC);
   wire sel_fl = (reg_addr == `BCRF_REG_FLAGS);
   wire sel_sp = (reg_addr == `BCRF_REG_SP);

   always_comb
   begin
      rdata_d = 16'h0000;
      if (sel_ctrl)
      begin
         rdata_d[`BCRF_CTRL_RUN] = run_q;
      end
      else if (sel_pc)
      begin
         rdata_d[PC_W-1:0] = pc_q;
      end
      else if (sel_fl)
      begin
         rdata_d[3:0] = {ime_q, flags_q};
      end
      else if (sel_sp)
      begin
         rdata_d[SP_W-1:0] = sp_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         run_q <= `BCRF_CTRL_RST;
         rdata_q <= 16'h0000;
      end
      else
      begin
         if (reg_wr & sel_ctrl)
         begin
            run_q <= reg_wdata[`BCRF_CTRL_RUN];
         end
         rdata_q <= reg_rd ? rdata_d : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign ime = ime_q;
   assign flags = flags_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   wire no_sw = ~reg_wr;
   sequence s_exit_dec;
      in_decode && (is_sub_exit || is_int_exit) && no_sw;
   endsequence
   // pop cycle directly follows the decode, load the cycle after it
   sequence s_pop_load;
      (state_q == ST_POP) ##1 (state_q == ST_LOAD);
   endsequence

   a_page_taken: assert property (in_decode && is_page_br && stat_fl && no_sw
      |=> pc_q == {$past(pc_q[PC_W-1:6]), $past(op[5:0])})
      else $error("in-page branch target wrong");
   a_page_carry: assert property (in_decode && is_page_br && stat_fl
      && (pc_q[5:0] == 6'h00) && no_sw |=> pc_q[PC_W-1:6] == $past(pc_q[PC_W-1:6]))
      else $error("in-page branch upper bits not from advanced pc");
   a_page_skip: assert property (in_decode && is_page_br && !stat_fl && no_sw
      |=> flags_q[2] && pc_q == $past(pc_q) && state_q == ST_FETCH)
      else $error("in-page branch with status clear misbehaved");
   a_call_push: assert property (state_q == ST_DECODE2 && no_sw
      |-> push && stk_wdata[PC_W-1:0] == pc_q ##1 sp_q == $past(sp_q) - SP_W'(1)
      && pc_q == $past(call_tgt))
      else $error("long call push or target wrong");
   a_call_order: assert property (in_decode && is_call && no_sw
      |-> !push ##1 pm_rd ##1 push && pc_q == $past(pc_q, 2) + PC_W'(1))
      else $error("long call pushed before second byte");
   a_vec_call: assert property (in_decode && is_vec_call && no_sw
      |=> pc_q == (($past(op[3:0]) == 4'h0) ? 12'h086 : 12'h006 + {5'h00, $past(op[3:0]), 3'h0})
      && sp_q == $past(sp_q) - SP_W'(1))
      else $error("short vector call target wrong");
   a_exit_pop: assert property (s_exit_dec
      |=> sp_q == $past(sp_q) + SP_W'(1) ##0 s_pop_load)
      else $error("exit did not increment pointer before load");
   a_int_exit_ime: assert property (state_q == ST_LOAD && int_exit_q
      |=> ime_q && flags_q == $past(stk_rdata[PC_W+2:PC_W]))
      else $error("interrupt exit did not restore flags or enable");
   a_idle_op: assert property (in_decode && is_idle && !upd_valid && no_sw
      |=> flags_q == $past(flags_q) && state_q == ST_FETCH && sp_q == $past(sp_q))
      else $error("idle op changed state");
   a_zero_acc: assert property (state_q == ST_FETCH && upd_valid && zero_sel == FS_Z
      && z_src == ZS_ACC |=> flags_q[1] == ($past(acc_val) == 4'h0))
      else $error("zero flag not from accumulator value");
   a_carry_add: assert property (state_q == ST_FETCH && upd_valid && carry_sel == FS_CY
      && cy_src == CS_ADD |=> flags_q[0] == $past(add_carry))
      else $error("carry flag not from adder carry");
endmodule : bcrf_decoder

// [rtl/bcrf_flag_unit.sv]
// next-value logic for carry, zero and status flags
`timescale 1ns/1ps
module bcrf_flag_unit (
   input bcrf_pkg::bcrf_fsel_t carry_sel, // carry flag action
   input bcrf_pkg::bcrf_fsel_t zero_sel, // zero flag action
   input bcrf_pkg::bcrf_fsel_t stat_sel, // status flag action
   input bcrf_pkg::bcrf_csrc_t cy_src, // carry source
   input bcrf_pkg::bcrf_zsrc_t z_src, // zero source
   input wire logic add_carry, // adder msb carry
   input wire logic sub_borrow, // subtractor msb borrow
   input wire logic shift_out, // bit shifted out of accumulator
   input wire logic [3:0] alu_res, // alu result
   input wire logic [3:0] acc_val, // value moved into accumulator
   input wire logic [3:0] l_res, // l register inc or dec result
   input wire logic [2:0] flags, // current {status, zero, carry}
   output logic [2:0] flags_n // new {status, zero, carry}
);
   import bcrf_pkg::*;
   logic cy;
   logic [3:0] zval;
   logic z;

   assign cy = (cy_src == CS_SUB) ? sub_borrow : (cy_src == CS_SHIFT) ? shift_out : add_carry;
   assign zval = (z_src == ZS_ACC) ? acc_val : (z_src == ZS_LREG) ? l_res : alu_res;
   assign z = (zval == 4'h0);

   function automatic logic pick(bcrf_fsel_t s, logic cur, logic c, logic zz);
      case (s)
         FS_CY: pick = c;
         FS_NCY: pick = ~c;
         FS_Z: pick = zz;
         FS_NZ: pick = ~zz;
         FS_ONE: pick = 1'b1;
         FS_ZERO: pick = 1'b0;
         default: pick = cur;
      endcase
   endfunction : pick

   // each flag takes its own listed value, or keeps its state
   assign flags_n[0] = pick(carry_sel, flags[0], cy, z);
   assign flags_n[1] = pick(zero_sel, flags[1], cy, z);
   assign flags_n[2] = pick(stat_sel, flags[2], cy, z);
endmodule : bcrf_flag_unit

// [rtl/bcrf_stack_mem.sv]
// return stack storage with registered read data
`timescale 1ns/1ps
module bcrf_stack_mem #(
   parameter int W = 15,
   parameter int AW = 4
) (
   input wire logic clk_sys, // system clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write slot
   input wire logic [W-1:0] wdata, // write word
   input wire logic re, // read strobe
   input wire logic [AW-1:0] raddr, // read slot
   output logic [W-1:0] rdata_q // read word, one cycle later
);
   logic [W-1:0] mem [2**AW];

   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      if (re)
      begin
         rdata_q <= mem[raddr];
      end
   end
endmodule : bcrf_stack_mem

// [shared/bcrf_consts.svh]
// constants for the branch, call, return and flag block
`ifndef BCRF_CONSTS_SVH
`define BCRF_CONSTS_SVH
`define BCRF_PC_W 12
`define BCRF_SP_W 4
`define BCRF_FL_W 3
`define BCRF_PC_RST 12'h000
`define BCRF_SP_RST 4'hF
`define BCRF_OP_IDLE 8'h00
`define BCRF_OP_SUB_EXIT 8'h2A
`define BCRF_OP_INT_EXIT 8'h2B
`define BCRF_PFX_PAGE 2'h2
`define BCRF_PFX_CALL 5'h04
`define BCRF_PFX_VEC 4'h7
`define BCRF_VEC_ZERO 12'h086
`define BCRF_VEC_OFS 12'h006
`define BCRF_REG_CTRL 3'h0
`define BCRF_REG_PC 3'h1
`define BCRF_REG_FLAGS 3'h2
`define BCRF_REG_SP 3'h3
`define BCRF_CTRL_RUN 0
`define BCRF_CTRL_RST 1'h0
`endif

// [shared/bcrf_pkg.sv]
// types for the branch, call, return and flag block
package bcrf_pkg;
   typedef enum logic [2:0] {FS_KEEP, FS_CY, FS_NCY, FS_Z, FS_NZ, FS_ONE, FS_ZERO} bcrf_fsel_t;
   typedef enum logic [1:0] {CS_ADD, CS_SUB, CS_SHIFT} bcrf_csrc_t;
   typedef enum logic [1:0] {ZS_ALU, ZS_ACC, ZS_LREG} bcrf_zsrc_t;
   typedef enum logic [2:0] {ST_FETCH, ST_DECODE, ST_FETCH2, ST_DECODE2, ST_POP, ST_LOAD}
      bcrf_state_t;
endpackage : bcrf_pkg

// [tb/bcrf_pm_model.sv]
// program memory model answering fetches one cycle later
`timescale 1ns/1ps
module bcrf_pm_model (
   input wire logic clk_sys, // system clock
   input wire logic pm_rd, // fetch strobe
   input wire logic [11:0] pm_addr, // fetch address
   output logic [7:0] pm_data // byte, valid in the cycle after pm_rd
);
   logic [7:0] mem [0:4095];
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      pm_data = 8'h00;
   end
   // byte stands for the decode cycle only, then the inverse shows
   always @(posedge clk_sys)
   begin
      if (pm_rd)
         pm_data <= mem[pm_addr];
      else
         pm_data <= ~pm_data;
   end
endmodule : bcrf_pm_model

// [tb/branch_call_return_flags_tb.sv]
// self-checking bench for the control-flow decoder
`timescale 1ns/1ps
module branch_call_return_flags_tb;
   import bcrf_pkg::*;
   typedef logic [11:0] bcrf_tb_aq_t [$];
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic pm_rd;
   logic [11:0] pm_addr;
   logic [7:0] pm_data;
   logic upd_valid = 1'b0;
   bcrf_fsel_t carry_sel = FS_KEEP;
   bcrf_fsel_t zero_sel = FS_KEEP;
   bcrf_fsel_t stat_sel = FS_KEEP;
   logic other_go;
   logic [7:0] other_op;
   logic [7:0] oth_seen = 8'h00;
   bcrf_csrc_t cy_src = CS_ADD;
   bcrf_zsrc_t z_src = ZS_ALU;
   logic add_carry = 1'b0;
   logic sub_borrow = 1'b0;
   logic shift_out = 1'b0;
   logic [3:0] alu_res = 4'h0;
   logic [3:0] acc_val = 4'h0;
   logic [3:0] l_res = 4'h0;
   logic ime_clr = 1'b0;
   logic ime;
   logic [2:0] flags;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   int err_count = 0;
   int compares = 0;
   logic [11:0] fa [$];
   logic [3:0] ff [$];

   bcrf_decoder bcrf_decoder_i (.clk_sys(clk_sys), .rstn(rstn), .pm_rd(pm_rd),
      .pm_addr(pm_addr), .pm_data(pm_data), .other_go(other_go), .other_op(other_op),
      .upd_valid(upd_valid), .carry_sel(carry_sel), .zero_sel(zero_sel), .stat_sel(stat_sel),
      .cy_src(cy_src), .z_src(z_src), .add_carry(add_carry), .sub_borrow(sub_borrow),
      .shift_out(shift_out), .alu_res(alu_res), .acc_val(acc_val), .l_res(l_res),
      .ime_clr(ime_clr), .ime(ime), .flags(flags), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   bcrf_pm_model bcrf_pm_model_i (.clk_sys(clk_sys), .pm_rd(pm_rd), .pm_addr(pm_addr),
      .pm_data(pm_data));

   initial
   begin
      forever
         #50 clk_sys = ~clk_sys;
   end

   // fetch trace with the flags seen at each fetch
   always @(posedge clk_sys)
   begin
      if (pm_rd === 1'b1)
      begin
         fa.push_back(pm_addr);
         ff.push_back({ime, flags});
      end
      // last opcode handed on to the other units
      if (other_go === 1'b1)
      begin
         oth_seen <= other_op;
      end
   end

   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
   endtask : do_reset

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      check(what, reg_rdata, exp);
   endtask : rd_chk

   task automatic run_prog(input logic [11:0] pc, input int ncyc);
      wr(3'h1, {4'h0, pc});
      fa.delete();
      ff.delete();
      wr(3'h0, 16'h0001);
      repeat (ncyc) @(posedge clk_sys);
      wr(3'h0, 16'h0000);
      repeat (6) @(posedge clk_sys);
   endtask : run_prog

   task automatic tr_chk(input string what, input bcrf_tb_aq_t e);
      foreach (e[i])
         check(what, (i < fa.size()) ? {4'h0, fa[i]} : 16'hFFFF, {4'h0, e[i]});
   endtask : tr_chk

   task automatic fl(input bcrf_fsel_t c, input bcrf_fsel_t z, input bcrf_fsel_t s,
      input bcrf_csrc_t cs, input bcrf_zsrc_t zs, input logic [2:0] b,
      input logic [11:0] v, input logic [3:0] exp);
      @(posedge clk_sys);
      carry_sel <= c;
      zero_sel <= z;
      stat_sel <= s;
      cy_src <= cs;
      z_src <= zs;
      {add_carry, sub_borrow, shift_out} <= b;
      {alu_res, acc_val, l_res} <= v;
      upd_valid <= 1'b1;
      @(posedge clk_sys);
      upd_valid <= 1'b0;
      rd_chk("flags", 3'h2, {12'h000, exp});
   endtask : fl

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      do_reset();
      rd_chk("ctrl", 3'h0, 16'h0000);
      rd_chk("pc", 3'h1, 16'h0000);
      rd_chk("sp", 3'h3, 16'h000F);
      rd_chk("flags", 3'h2, 16'h0000);
      wr(3'h5, 16'h1234);
      rd_chk("unmapped", 3'h5, 16'h0000);
      wr(3'h2, 16'h0007);
      rd_chk("flags ro", 3'h2, 16'h0000);
      wr(3'h1, 16'h0ABC);
      rd_chk("pc rw", 3'h1, 16'h0ABC);
      wr(3'h3, 16'h0003);
      rd_chk("sp rw", 3'h3, 16'h0003);
      $display("test regs done");
   endtask : t_regs

   task automatic t_branch();
      do_reset();
      bcrf_pm_model_i.mem[12'h03E] = 8'h85;
      bcrf_pm_model_i.mem[12'h03F] = 8'h90;
      bcrf_pm_model_i.mem[12'h051] = 8'h3C;
      bcrf_pm_model_i.mem[12'h052] = 8'h91;
      run_prog(12'h03E, 20);
      tr_chk("branch trace", '{12'h03E, 12'h03F, 12'h050, 12'h051, 12'h052});
      check("idle flags", {12'h000, ff[3]}, 16'h0004);
      check("other op", {8'h00, oth_seen}, 16'h003C);
      $display("test branch done");
   endtask : t_branch

   task automatic t_call();
      do_reset();
      // long call target kept at or below 2047
      bcrf_pm_model_i.mem[12'h100] = 8'h22;
      bcrf_pm_model_i.mem[12'h101] = 8'h34;
      bcrf_pm_model_i.mem[12'h234] = 8'h73;
      bcrf_pm_model_i.mem[12'h01E] = 8'h2A;
      bcrf_pm_model_i.mem[12'h235] = 8'h2A;
      bcrf_pm_model_i.mem[12'h102] = 8'h70;
      bcrf_pm_model_i.mem[12'h086] = 8'h86;
      bcrf_pm_model_i.mem[12'h087] = 8'h86;
      run_prog(12'h100, 40);
      tr_chk("call trace", '{12'h100, 12'h101, 12'h234, 12'h01E, 12'h235, 12'h102,
         12'h086, 12'h087, 12'h086});
      rd_chk("sp after short_vector_jump", 3'h3, 16'h000E);
      $display("test call done");
   endtask : t_call

   task automatic t_int_exit();
      do_reset();
      fl(FS_ONE, FS_ONE, FS_ZERO, CS_ADD, ZS_ALU, 3'h0, 12'h000, 4'h3);
      bcrf_pm_model_i.mem[12'h200] = 8'h71;
      bcrf_pm_model_i.mem[12'h00E] = 8'h8F;
      bcrf_pm_model_i.mem[12'h00F] = 8'h2B;
      bcrf_pm_model_i.mem[12'h201] = 8'h81;
      bcrf_pm_model_i.mem[12'h202] = 8'h81;
      run_prog(12'h200, 30);
      tr_chk("exit trace", '{12'h200, 12'h00E, 12'h00F, 12'h201, 12'h202});
      check("restored flags", {12'h000, ff[3]}, 16'h000B);
      rd_chk("flags ime", 3'h2, 16'h000F);
      @(posedge clk_sys);
      ime_clr <= 1'b1;
      @(posedge clk_sys);
      ime_clr <= 1'b0;
      rd_chk("ime cleared", 3'h2, 16'h0007);
      $display("test int exit done");
   endtask : t_int_exit

   task automatic t_flags();
      do_reset();
      fl(FS_CY, FS_Z, FS_ONE, CS_ADD, ZS_ALU, 3'h4, 12'h0FF, 4'h7);
      fl(FS_NCY, FS_NZ, FS_KEEP, CS_SUB, ZS_ACC, 3'h2, 12'hF0F, 4'h4);
      fl(FS_CY, FS_Z, FS_NZ, CS_SHIFT, ZS_LREG, 3'h1, 12'h005, 4'h5);
      fl(FS_KEEP, FS_KEEP, FS_KEEP, CS_SUB, ZS_ALU, 3'h0, 12'h000, 4'h5);
      fl(FS_ZERO, FS_Z, FS_ZERO, CS_ADD, ZS_ACC, 3'h7, 12'hF0F, 4'h2);
      fl(FS_NCY, FS_Z, FS_Z, CS_ADD, ZS_ALU, 3'h2, 12'h800, 4'h1);
      $display("test flags done");
   endtask : t_flags

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   initial
   begin
      t_regs();
      t_branch();
      t_call();
      t_int_exit();
      t_flags();
      end_sim();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      end_sim();
   end
endmodule : branch_call_return_flags_tb
